/* rtl/lts_pkg.sv */
// Package of constants and types for the limit test sequencer.
package lts_pkg;
  // ---------------------------------------------------------------------
  // Test slots
  // ---------------------------------------------------------------------
  localparam int LTS_NUM_TESTS = 11;
  localparam int LTS_IDX_W = 4;
  localparam logic [3:0] LTS_SLOT_COMPL = 4'h0;
  localparam logic [3:0] LTS_SLOT_LAST = 4'ha;
  localparam logic [3:0] LTS_NUM_COARSE = 4'h2;
  localparam logic [3:0] LTS_NUM_SKIP = 4'h4;
  localparam logic [3:0] LTS_CYCLES_RST = 4'h1;
  localparam logic [7:0] LTS_PAT_RST = 8'h00;
  localparam logic [10:0] LTS_RES_RST = 11'h000;
  localparam logic [1:0] LTS_IND_RST = 2'h0;
  // ---------------------------------------------------------------------
  // Indication and state encodings
  // ---------------------------------------------------------------------
  localparam logic [1:0] LTS_IND_NONE = 2'h0;
  localparam logic [1:0] LTS_IND_PASS = 2'h1;
  localparam logic [1:0] LTS_IND_FAIL = 2'h2;
  typedef enum logic [3:0] {
    LTS_IDLE = 4'h1,
    LTS_WAIT = 4'h2,
    LTS_EVAL = 4'h4,
    LTS_DONE = 4'h8
  } lts_state_t;
endpackage

/* rtl/lts_window_check.sv */
// Window and compliance comparator for one limit test.
`timescale 1ns/10ps
module lts_window_check #(
  parameter int W = 16
) (
  input wire logic is_compliance,
  input wire logic signed [W-1:0] value,
  input wire logic signed [W-1:0] high_limit,
  input wire logic signed [W-1:0] low_limit,
  output logic pass
);
  // ---------------------------------------------------------------------
  // Comparison
  // ---------------------------------------------------------------------
  // Compliance fails at or above its limit; windows pass inside LO..HI.
  always_comb begin
    if (is_compliance) begin
      pass = (value < high_limit);
    end else begin
      pass = (value >= low_limit) && (value <= high_limit);
    end
  end
endmodule

/* rtl/lts_sequencer.sv */
// Limit test sequencer: runs enabled tests and reports the outcome.
`timescale 1ns/10ps
module lts_sequencer #(
  parameter int W = 16,
  parameter int PW = 8,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start_of_test_strobe,
  input wire logic sorting_mode,
  input wire logic [10:0] test_enable,
  input wire logic [3:0] element_count,
  input wire logic meas_valid,
  input wire logic signed [W-1:0] meas_value,
  input wire logic signed [W-1:0] compliance_limit,
  input wire logic signed [W*11-1:0] high_limits,
  input wire logic signed [W*11-1:0] low_limits,
  input wire logic [PW-1:0] pass_pattern,
  input wire logic [PW*11-1:0] fail_patterns,
  input wire logic [AW-1:0] meas_location,
  input wire logic [3:0] per_limit_result_query,
  output logic per_limit_fail,
  output logic [1:0] indication,
  output logic [PW-1:0] port_pattern,
  output logic port_valid,
  output logic busy,
  output logic meas_ready,
  output logic tag_valid,
  output logic tag_fail,
  output logic [AW-1:0] tag_location
);
  // ---------------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------------
  typedef struct packed {
    lts_pkg::lts_state_t state;
    logic [3:0] slot;
    logic [3:0] elem;
    logic [10:0] fails;
    logic elem_fail;
    logic first_fail_seen;
    logic [3:0] first_fail_slot;
    logic [1:0] ind;
    logic [PW-1:0] pat;
    logic pvalid;
    logic tvalid;
    logic tfail;
    logic [AW-1:0] tloc;
    logic strobe_s1;
    logic strobe_s2;
    logic strobe_s3;
    logic signed [W-1:0] value;
  } lts_regs_t;

  lts_regs_t r;
  lts_regs_t next_r;

  // ---------------------------------------------------------------------
  // Comparator
  // ---------------------------------------------------------------------
  logic slot_pass;
  logic signed [W-1:0] sel_high;
  logic signed [W-1:0] sel_low;
  logic [10:0] later_en;
  logic any_window_en;
  logic strobe_rise;

  // Compliance uses its own limit; other slots pick their window.
  always_comb begin
    if (r.slot == lts_pkg::LTS_SLOT_COMPL) begin
      sel_high = compliance_limit;
      sel_low = compliance_limit;
    end else begin
      sel_high = high_limits[r.slot*W +: W];
      sel_low = low_limits[r.slot*W +: W];
    end
  end

  lts_window_check #(
    .W(W)
  ) u_check (
    .is_compliance(r.slot == lts_pkg::LTS_SLOT_COMPL),
    .value(r.value),
    .high_limit(sel_high),
    .low_limit(sel_low),
    .pass(slot_pass)
  );

  // Mask of enabled slots strictly above the current one.
  genvar gi;
  generate
    for (gi = 0; gi < 11; gi++) begin : g_later
      assign later_en[gi] = test_enable[gi] && (gi > r.slot);
    end
  endgenerate

  assign any_window_en = |test_enable[10:1];
  // The strobe is a pin, so only the synchronised copy is edge detected.
  assign strobe_rise = r.strobe_s2 && !r.strobe_s3;

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    logic done_elem;
    logic final_pass;
    logic [3:0] nxt;
    done_elem = 1'b0;
    final_pass = 1'b0;
    nxt = lts_pkg::LTS_SLOT_COMPL;
    next_r = r;
    next_r.strobe_s1 = start_of_test_strobe;
    next_r.strobe_s2 = r.strobe_s1;
    next_r.strobe_s3 = r.strobe_s2;
    next_r.tvalid = 1'b0;
    // Lowest enabled slot above the current one.
    for (int i = 10; i >= 0; i--) begin
      if (later_en[i]) begin
        nxt = 4'(i);
      end
    end
    unique case (r.state)
      lts_pkg::LTS_IDLE, lts_pkg::LTS_DONE: begin
        // Results are frozen here until a fresh strobe.
        if (strobe_rise) begin
          next_r.state = lts_pkg::LTS_WAIT;
          next_r.elem = lts_pkg::LTS_CYCLES_RST;
          next_r.fails = lts_pkg::LTS_RES_RST;
          next_r.first_fail_seen = 1'b0;
          next_r.ind = lts_pkg::LTS_IND_NONE;
          next_r.pvalid = 1'b0;
        end
      end
      lts_pkg::LTS_WAIT: begin
        if (meas_valid) begin
          next_r.value = meas_value;
          next_r.tloc = meas_location;
          next_r.elem_fail = 1'b0;
          next_r.state = lts_pkg::LTS_EVAL;
          next_r.slot = lts_pkg::LTS_SLOT_COMPL;
          // Compliance check is skipped when disabled.
          if (!test_enable[0]) begin
            next_r.slot = 4'(LTS_first_window(test_enable));
          end
        end
      end
      lts_pkg::LTS_EVAL: begin
        if (r.slot > lts_pkg::LTS_SLOT_LAST) begin
          // Nothing enabled at all: trivially passing.
          done_elem = 1'b1;
          final_pass = 1'b1;
        end else begin
          next_r.fails[r.slot] = !slot_pass;
          if (r.slot == lts_pkg::LTS_SLOT_COMPL) begin
            if (!slot_pass) begin
              done_elem = 1'b1;
            end else if (!any_window_en) begin
              done_elem = 1'b1;
              final_pass = 1'b1;
            end else begin
              next_r.slot = nxt;
            end
          end else if (sorting_mode) begin
            if (slot_pass) begin
              done_elem = 1'b1;
              final_pass = 1'b1;
            end else if (later_en == 11'h000) begin
              done_elem = 1'b1;
            end else begin
              next_r.slot = nxt;
            end
          end else begin
            if (!slot_pass) begin
              done_elem = 1'b1;
            end else if (later_en == 11'h000) begin
              done_elem = 1'b1;
              final_pass = 1'b1;
            end else begin
              next_r.slot = nxt;
            end
          end
        end
        if (done_elem) begin
          next_r.tvalid = 1'b1;
          next_r.tfail = !final_pass;
          if (!final_pass && !r.first_fail_seen) begin
            // The first failure of a package picks the bin.
            next_r.first_fail_seen = 1'b1;
            next_r.first_fail_slot = r.slot;
          end
          // Grading repeats for each element of a package.
          if (!sorting_mode && r.elem < element_count) begin
            next_r.elem = r.elem + 4'h1;
            next_r.state = lts_pkg::LTS_WAIT;
          end else begin
            next_r.state = lts_pkg::LTS_DONE;
            next_r.pvalid = 1'b1;
            if (final_pass && !r.first_fail_seen) begin
              next_r.ind = lts_pkg::LTS_IND_PASS;
              next_r.pat = pass_pattern;
            end else begin
              next_r.ind = lts_pkg::LTS_IND_FAIL;
              // A failure with no earlier failing element uses the current slot.
              next_r.pat = r.first_fail_seen ?
                fail_patterns[r.first_fail_slot*PW +: PW] :
                fail_patterns[r.slot*PW +: PW];
            end
          end
        end
      end
      default: begin
        next_r.state = lts_pkg::LTS_IDLE;
      end
    endcase
  end

  // First enabled windowed slot, or one past the end if none.
  function automatic int LTS_first_window(input logic [10:0] en);
    int k;
    k = 11;
    for (int i = 10; i >= 1; i--) begin
      if (en[i]) begin
        k = i;
      end
    end
    return k;
  endfunction

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.state <= lts_pkg::LTS_IDLE;
      r.elem <= lts_pkg::LTS_CYCLES_RST;
      r.ind <= lts_pkg::LTS_IND_RST;
      r.pat <= lts_pkg::LTS_PAT_RST;
      r.fails <= lts_pkg::LTS_RES_RST;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // Query maps test numbers 1..3 and 5..12 onto slots; 4 reads as pass.
  always_comb begin
    per_limit_fail = 1'b0;
    if (per_limit_result_query >= 4'h1 &&
        per_limit_result_query < lts_pkg::LTS_NUM_SKIP) begin
      per_limit_fail = r.fails[per_limit_result_query - 4'h1];
    end else if (per_limit_result_query > lts_pkg::LTS_NUM_SKIP &&
                 per_limit_result_query <= 4'hc) begin
      per_limit_fail = r.fails[per_limit_result_query - 4'h2];
    end
  end

  assign indication = r.ind;
  assign port_pattern = r.pat;
  assign port_valid = r.pvalid;
  assign busy = (r.state == lts_pkg::LTS_WAIT) ||
                (r.state == lts_pkg::LTS_EVAL);
  assign meas_ready = (r.state == lts_pkg::LTS_WAIT);
  assign tag_valid = r.tvalid;
  assign tag_fail = r.tfail;
  assign tag_location = r.tloc;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  a_result_hold: assert property (@(posedge clk) disable iff (rst)
    (r.state == lts_pkg::LTS_DONE && !strobe_rise) |=>
      ($stable(r.pat) && $stable(r.ind) && $stable(r.fails)))
    else $error("Result changed while holding.");

  a_wait_strobe: assert property (@(posedge clk) disable iff (rst)
    (r.state == lts_pkg::LTS_IDLE && !strobe_rise) |=>
      r.state == lts_pkg::LTS_IDLE)
    else $error("Sequence began without strobe.");

  a_compl_fail: assert property (@(posedge clk) disable iff (rst)
    (r.state == lts_pkg::LTS_EVAL && r.slot == lts_pkg::LTS_SLOT_COMPL &&
     r.value >= compliance_limit) |=> (tag_valid && tag_fail))
    else $error("Compliance failure did not end element.");

  a_grade_fail: assert property (@(posedge clk) disable iff (rst)
    (r.state == lts_pkg::LTS_EVAL && !sorting_mode &&
     r.slot != lts_pkg::LTS_SLOT_COMPL && r.slot <= lts_pkg::LTS_SLOT_LAST
     && !slot_pass) |=> tag_valid && tag_fail)
    else $error("Grading failure did not stop.");

  a_sort_pass: assert property (@(posedge clk) disable iff (rst)
    (r.state == lts_pkg::LTS_EVAL && sorting_mode &&
     r.slot != lts_pkg::LTS_SLOT_COMPL && r.slot <= lts_pkg::LTS_SLOT_LAST
     && slot_pass) |=> (indication == lts_pkg::LTS_IND_PASS))
    else $error("Sorting pass did not give PASS.");

  a_order_up: assert property (@(posedge clk) disable iff (rst)
    (r.state == lts_pkg::LTS_EVAL && next_r.state == lts_pkg::LTS_EVAL)
      |=> (r.slot > $past(r.slot)) && test_enable[r.slot])
    else $error("Slot order broken or disabled slot run.");

  a_window_res: assert property (@(posedge clk) disable iff (rst)
    (r.state == lts_pkg::LTS_EVAL && r.slot != lts_pkg::LTS_SLOT_COMPL &&
     r.slot <= lts_pkg::LTS_SLOT_LAST) |=>
      r.fails[$past(r.slot)] == !($past(r.value) >= $past(sel_low) &&
                                 $past(r.value) <= $past(sel_high)))
    else $error("Window result stored wrong.");

  a_pass_pat: assert property (@(posedge clk) disable iff (rst)
    (port_valid && indication == lts_pkg::LTS_IND_PASS &&
     r.state == lts_pkg::LTS_DONE && $rose(port_valid)) |->
      port_pattern == $past(pass_pattern))
    else $error("Pass pattern not driven.");
endmodule

/* testbench/lts_handler_model.sv */
// Component handler model that starts each package and bins the result.
`timescale 1ns/10ps
module lts_handler_model (
  input wire logic clk,
  input wire logic go,
  input wire logic port_valid,
  input wire logic [7:0] port_pattern,
  output logic strobe,
  output logic [7:0] bin
);
  int hold = 0;
  logic pv_q = 1'b0;
  logic stb = 1'b0;
  logic [7:0] bin_q = 8'h00;
  // ---------------------------------------------------------------------
  // Strobe and binning
  // ---------------------------------------------------------------------
  // Four cycles high outlasts the two-flop synchroniser on the far side.
  assign strobe = stb;
  assign bin = bin_q;
  always @(posedge clk) begin
    if (go && hold == 0) begin
      stb <= 1'b1;
      hold <= 4;
    end else if (hold > 0) begin
      hold <= hold - 1;
      if (hold == 1) stb <= 1'b0;
    end
    if (port_valid && !pv_q) bin_q <= port_pattern;
    pv_q <= port_valid;
  end
endmodule

/* testbench/limit_test_sequencer_tb.sv */
// Self-checking bench for the limit test sequencer.
`timescale 1ns/10ps
module limit_test_sequencer_tb;
  logic clk = 1'b0, rst = 1'b1, strobe, sm = 1'b0, mv = 1'b0, go = 1'b0;
  logic [10:0] en = 11'h000, ef;
  logic [3:0] ec = 4'h1, q = 4'h1;
  logic signed [15:0] v = 16'sh0000, cl = 16'sh0010;
  logic [175:0] hl = 176'h0, ll = 176'h0;
  logic [7:0] pp = 8'h00, bin, fpat;
  logic [87:0] fp = 88'h0;
  logic [11:0] loc = 12'h000;
  logic plf, pvld, busy, mrdy, tv, tf, anyf, ef_elem;
  logic [1:0] ind;
  logic [7:0] pat;
  logic [11:0] tloc;
  int error_cnt = 0, samples_checked = 0, seed = 32'h8d33;
  // ---------------------------------------------------------------------
  // Clock, design and handler
  // ---------------------------------------------------------------------
  always #2.5 clk = ~clk;
  lts_sequencer lts_sequencer_inst (.clk(clk), .rst(rst),
    .start_of_test_strobe(strobe), .sorting_mode(sm), .test_enable(en),
    .element_count(ec), .meas_valid(mv), .meas_value(v),
    .compliance_limit(cl), .high_limits(hl), .low_limits(ll),
    .pass_pattern(pp), .fail_patterns(fp), .meas_location(loc),
    .per_limit_result_query(q), .per_limit_fail(plf), .indication(ind),
    .port_pattern(pat), .port_valid(pvld), .busy(busy),
    .meas_ready(mrdy), .tag_valid(tv), .tag_fail(tf), .tag_location(tloc));
  lts_handler_model lts_handler_model_inst (.clk(clk), .go(go),
    .port_valid(pvld), .port_pattern(pat), .strobe(strobe), .bin(bin));
  // ---------------------------------------------------------------------
  // Checking and expectation
  // ---------------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Works out one element's outcome; the slot that ends the first failing element sets the bin.
  // Each element that reaches a test overwrites that test's stored result.
  function automatic void elem_exp(input logic signed [15:0] x);
    logic stop, ok;
    int last;
    stop = 1'b0;
    ef_elem = 1'b0;
    last = 0;
    if (en[0]) begin
      ef[0] = (x >= cl);
      stop = ef[0];
      ef_elem = ef[0];
    end
    for (int k = 1; k < 11; k++) begin
      if (!stop && en[k]) begin
        ok = x >= $signed(ll[k*16+:16]) && x <= $signed(hl[k*16+:16]);
        ef_elem = !ok;
        ef[k] = !ok;
        if (!ok) last = k;
        stop = sm ? ok : !ok;
      end
    end
    if (ef_elem && !anyf) fpat = fp[last*8+:8];
    if (ef_elem) anyf = 1'b1;
  endfunction
  // One package: strobe, one measurement per element, then the verdict.
  task automatic run_case(input logic m, input logic [10:0] e,
      input logic [3:0] c, input logic signed [15:0] x0, x1, x2);
    logic signed [15:0] xs [3];
    int n, t;
    logic pe;
    xs = '{x0, x1, x2};
    n = (m || c < 2) ? 1 : c;
    @(posedge clk);
    sm <= m;
    en <= e;
    ec <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    ef = 11'h000;
    anyf = 1'b0;
    fpat = 8'h00;
    for (int i = 0; i < n; i++) begin
      elem_exp(xs[i]);
      for (t = 0; t < 20 && mrdy !== 1'b1; t++) @(posedge clk) #1;
      check("meas_ready", mrdy, 1'b1);
      check("busy", busy, 1'b1);
      check("port_valid", pvld, 1'b0);
      @(posedge clk);
      v <= xs[i];
      loc <= 12'($random(seed));
      mv <= 1'b1;
      @(posedge clk);
      mv <= 1'b0;
      for (t = 0; t < 20; t++) begin
        @(posedge clk) #1;
        if (tv === 1'b1) break;
      end
      check("tag_valid", tv, 1'b1);
      check("tag_fail", tf, ef_elem);
      check("tag_location", tloc, loc);
    end
    check("port_valid", pvld, 1'b1);
    check("indication", ind, anyf ? 2'h2 : 2'h1);
    check("port_pattern", pat, anyf ? fpat : pp);
    for (int k = 1; k <= 12; k++) begin
      @(posedge clk);
      q <= 4'(k);
      #1;
      pe = (k == 4) ? 1'b0 : ef[k < 4 ? k - 1 : k - 2];
      check("per_limit_fail", plf, pe);
    end
    check("bin", bin, anyf ? fpat : pp);
    check("held", ind, anyf ? 2'h2 : 2'h1);
  endtask
  // ---------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    logic signed [15:0] lo;
    for (int k = 0; k < 11; k++) begin
      ll[k*16+:16] <= -16'sd10;
      hl[k*16+:16] <= 16'sd10;
      fp[k*8+:8] <= 8'(8'h10 + k);
    end
    pp <= 8'ha5;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    check("busy", busy, 1'b0);
    run_case(1'b0, 11'h000, 4'h1, 16'sd0, 16'sd0, 16'sd0);
    run_case(1'b0, 11'h7ff, 4'h1, 16'sd0, 16'sd0, 16'sd0);
    run_case(1'b0, 11'h7ff, 4'h1, 16'sd16, 16'sd0, 16'sd0);
    run_case(1'b1, 11'h001, 4'h1, 16'sd0, 16'sd0, 16'sd0);
    run_case(1'b1, 11'h7fe, 4'h1, -16'sd90, 16'sd0, 16'sd0);
    run_case(1'b0, 11'h7ff, 4'h3, -16'sd90, 16'sd90, 16'sd0);
    for (int r = 0; r < 60; r++) begin
      // New limits and patterns land on a clock edge, before the strobe.
      @(posedge clk);
      for (int k = 1; k < 11; k++) begin
        lo = 16'($random(seed) % 16);
        ll[k*16+:16] <= lo;
        hl[k*16+:16] <= lo + 16'($random(seed) & 15);
      end
      fp <= 88'({$random(seed), $random(seed), $random(seed)});
      pp <= 8'($random(seed));
      cl <= 16'(16 + ($random(seed) & 7));
      run_case(1'($random(seed)), 11'($random(seed)),
        4'($random(seed) & 3), 16'($random(seed) % 24),
        16'($random(seed) % 24), 16'($random(seed) % 24));
    end
    report_and_stop;
  end
endmodule
